// ---- hw/alu_subtract_rotate_swap_xor.sv ----
// APB-reached execution datapath: subtract, rotate, swap, xor, dir load
`timescale 1ns/10ps

// Function
// - Subtract computes file register minus accumulator; all three flags.
// - Destination bit 0 writes accumulator; 1 writes back the file register.
// - File operands use a five-bit address, registers 0 to 31.
// - Rotate right through carry; old carry to bit 7, bit 0 to carry.
// - Nibble swap exchanges upper and lower halves; no flags change.
// - Direction load copies accumulator to direction register 6 or 7.
// - Literal xor: accumulator xor immediate into accumulator; only Z changes.
// - Register xor: accumulator xor file register, routed by destination.
module alu_subtract_rotate_swap_xor #(
  parameter bit HAS_DIR1 = 1'b1
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port direction registers
  output logic      [7:0]  port_dir0,
  output logic      [7:0]  port_dir1
);

  logic [7:0]  file_r [32];
  logic [7:0]  acc_r;
  logic        flag_c_r;
  logic        flag_dig_r;
  logic        flag_z_r;
  logic [7:0]  dir0_r;
  logic [7:0]  dir1_r;
  logic [31:0] insn_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] rd_val;
  logic        setup;
  logic        wr;
  logic        exec;
  logic        insn_ok;
  logic        dest;
  logic [4:0]  fsel;
  logic        to_acc;
  logic        to_file;
  alu_pkg::op_type op_q;

  alu_if alu ();

  // File window decode, used by both read and write paths
  function automatic logic is_file(input logic [11:0] a);
    return a >= alu_pkg::ADDR_FILE && a <= alu_pkg::ADDR_FEND &&
           a[1:0] == 2'b00;
  endfunction

  // Word index of a file register in the window
  function automatic logic [4:0] file_idx(input logic [11:0] a);
    return a[6:2];
  endfunction

  // Instruction fields straight from write data
  assign op_q  = alu_pkg::op_type'(pwdata[alu_pkg::OP_LSB +: 3]);
  assign dest  = pwdata[alu_pkg::DEST_BIT];
  assign fsel  = pwdata[alu_pkg::FSEL_LSB +: 5];

  // Direction load only accepts its two selectors
  always_comb begin
    insn_ok = pwdata[alu_pkg::OP_LSB +: 3] <= alu_pkg::OP_LAST;
    if (op_q == alu_pkg::OP_DIR) begin
      insn_ok = fsel == alu_pkg::DIR_SEL0 ||
                (HAS_DIR1 && fsel == alu_pkg::DIR_SEL1);
    end
  end

  // Bus phases; a write lands only at the completing access edge
  assign setup = pce & psel & ~penable;
  assign wr    = pce & psel & penable & pready_r & pwrite;
  assign exec  = wr & (paddr == alu_pkg::ADDR_INSN) & insn_ok;

  // Destination routing; literal xor always targets the accumulator
  assign to_acc  = op_q == alu_pkg::OP_XORL ||
                   (!dest && op_q != alu_pkg::OP_DIR);
  assign to_file = dest && op_q != alu_pkg::OP_DIR &&
                   op_q != alu_pkg::OP_XORL;

  // Operands into the ALU
  assign alu.op   = op_q;
  assign alu.acc  = acc_r;
  assign alu.opnd = file_r[fsel];
  assign alu.lit  = pwdata[alu_pkg::LIT_LSB +: 8];
  assign alu.c_in = flag_c_r;

  alu_exec u_exec (
    .bus (alu.core)
  );

  // Read mux, sampled in the setup phase
  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_file(paddr)) begin
      rd_val = {24'h00_0000, file_r[file_idx(paddr)]};
    end else begin
      unique case (paddr)
        alu_pkg::ADDR_INSN:  rd_val = insn_r;
        alu_pkg::ADDR_ACC:   rd_val = {24'h00_0000, acc_r};
        alu_pkg::ADDR_FLAGS: rd_val = {29'h0000_0000, flag_z_r,
                                       flag_dig_r, flag_c_r};
        alu_pkg::ADDR_DIR0:  rd_val = {24'h00_0000, dir0_r};
        alu_pkg::ADDR_DIR1:  rd_val = {24'h00_0000, dir1_r};
        default:             rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Ready one cycle after setup: every access has zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else if (pce) begin
      pready_r <= setup;
    end
  end

  // Read data and error captured at setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_r <= !(is_file(paddr) || paddr == alu_pkg::ADDR_INSN ||
                     paddr == alu_pkg::ADDR_ACC ||
                     paddr == alu_pkg::ADDR_FLAGS ||
                     paddr == alu_pkg::ADDR_DIR0 ||
                     paddr == alu_pkg::ADDR_DIR1) ||
                   (pwrite && paddr == alu_pkg::ADDR_INSN && !insn_ok);
    end
  end

  // Last accepted instruction word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn_r <= alu_pkg::INSN_RST;
    end else if (exec) begin
      insn_r <= pwdata;
    end
  end

  // File registers: no reset, plain storage
  always_ff @(posedge pclk) begin
    if (wr && is_file(paddr)) begin
      file_r[file_idx(paddr)] <= pwdata[7:0];
    end else if (exec && to_file) begin
      file_r[fsel] <= alu.result;
    end
  end

  // Accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= alu_pkg::ACC_RST;
    end else if (wr && paddr == alu_pkg::ADDR_ACC) begin
      acc_r <= pwdata[7:0];
    end else if (exec && to_acc) begin
      acc_r <= alu.result;
    end
  end

  // Flags change on a flags register write, or where the operation says so
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {flag_z_r, flag_dig_r, flag_c_r} <= alu_pkg::FLAGS_RST;
    end else if (wr && paddr == alu_pkg::ADDR_FLAGS) begin
      flag_c_r   <= pwdata[alu_pkg::FLAG_C];
      flag_dig_r <= pwdata[alu_pkg::FLAG_DIG];
      flag_z_r   <= pwdata[alu_pkg::FLAG_Z];
    end else if (exec) begin
      if (alu.wr_c) flag_c_r <= alu.c_out;
      if (alu.wr_dig) flag_dig_r <= alu.dig_out;
      if (alu.wr_z) flag_z_r <= alu.z_out;
    end
  end

  // Direction registers; reset to all inputs so pins start undriven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir0_r <= alu_pkg::DIR_RST;
      dir1_r <= alu_pkg::DIR_RST;
    end else if (wr && paddr == alu_pkg::ADDR_DIR0) begin
      dir0_r <= pwdata[7:0];
    end else if (wr && paddr == alu_pkg::ADDR_DIR1 && HAS_DIR1) begin
      dir1_r <= pwdata[7:0];
    end else if (exec && op_q == alu_pkg::OP_DIR) begin
      if (fsel == alu_pkg::DIR_SEL0) dir0_r <= alu.result;
      else dir1_r <= alu.result;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign port_dir0 = dir0_r;
  assign port_dir1 = dir1_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_run(alu_pkg::op_type o);
    exec && op_q == o;
  endsequence

  // Runs whose result goes to the accumulator
  sequence s_run_w(alu_pkg::op_type o);
    exec && op_q == o && !dest;
  endsequence

  property p_sub_res;
    s_run_w(alu_pkg::OP_SUB) |=> acc_r == $past(alu.opnd) - $past(acc_r);
  endproperty
  a_sub_res: assert property (p_sub_res)
    else $error("subtract result wrong");

  property p_sub_borrow;
    s_run(alu_pkg::OP_SUB) |=> flag_c_r == ($past(alu.opnd) >= $past(acc_r))
      && flag_dig_r == ($past(alu.opnd[3:0]) >= $past(acc_r[3:0]));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow)
    else $error("subtract carry flags wrong");

  property p_dest_file;
    exec && dest && op_q != alu_pkg::OP_XORL |=> $stable(acc_r);
  endproperty
  a_dest_file: assert property (p_dest_file)
    else $error("accumulator changed for file destination");

  property p_rotate;
    s_run_w(alu_pkg::OP_ROR) |=> acc_r == {$past(flag_c_r),
      $past(alu.opnd[7:1])} && flag_c_r == $past(alu.opnd[0]) &&
      $stable(flag_z_r) && $stable(flag_dig_r);
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("rotate through carry wrong");

  property p_swap;
    s_run_w(alu_pkg::OP_SWAP) |=> acc_r == {$past(alu.opnd[3:0]),
      $past(alu.opnd[7:4])} && $stable({flag_z_r, flag_dig_r, flag_c_r});
  endproperty
  a_swap: assert property (p_swap)
    else $error("nibble swap wrong");

  property p_dir;
    s_run(alu_pkg::OP_DIR) ##0 (fsel == alu_pkg::DIR_SEL0) |=>
      port_dir0 == $past(acc_r) && $stable(acc_r);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction load wrong");

  property p_xorl;
    s_run(alu_pkg::OP_XORL) |=> acc_r == ($past(acc_r) ^ $past(alu.lit))
      && $stable(flag_c_r) && $stable(flag_dig_r);
  endproperty
  a_xorl: assert property (p_xorl)
    else $error("literal xor wrong");

  property p_xorr;
    s_run_w(alu_pkg::OP_XORR) |=> acc_r == ($past(acc_r) ^ $past(alu.opnd))
      && $stable(flag_c_r);
  endproperty
  a_xorr: assert property (p_xorr)
    else $error("register xor wrong");

  property p_zero;
    exec && alu.wr_z |=> flag_z_r == ($past(alu.result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

endmodule

// ---- hw/alu_pkg.sv ----
// Shared constants and types of the subtract/rotate/swap/xor datapath
package alu_pkg;

  // Operation codes carried in the instruction register
  typedef enum logic [2:0] {
    OP_SUB,
    OP_ROR,
    OP_SWAP,
    OP_DIR,
    OP_XORL,
    OP_XORR
  } op_type;

  // Highest legal operation code; the two codes above it are refused
  localparam logic [2:0]  OP_LAST    = 3'h5;

  // Register byte offsets on the APB slave
  localparam logic [11:0] ADDR_INSN  = 12'h000;
  localparam logic [11:0] ADDR_ACC   = 12'h004;
  localparam logic [11:0] ADDR_FLAGS = 12'h008;
  localparam logic [11:0] ADDR_DIR0  = 12'h00C;
  localparam logic [11:0] ADDR_DIR1  = 12'h010;
  localparam logic [11:0] ADDR_FILE  = 12'h080;
  localparam logic [11:0] ADDR_FEND  = 12'h0FC;

  // Instruction word fields
  localparam int          OP_LSB     = 0;
  localparam int          DEST_BIT   = 3;
  localparam int          FSEL_LSB   = 4;
  localparam int          LIT_LSB    = 16;

  // Flag register bit positions
  localparam int          FLAG_C     = 0;
  localparam int          FLAG_DIG   = 1;
  localparam int          FLAG_Z     = 2;

  // Direction register selectors
  localparam logic [4:0]  DIR_SEL0   = 5'h06;
  localparam logic [4:0]  DIR_SEL1   = 5'h07;

  // Values after reset
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [7:0]  DIR_RST    = 8'hFF;
  localparam logic [2:0]  FLAGS_RST  = 3'h0;
  localparam logic [31:0] INSN_RST   = 32'h0000_0000;

endpackage

// ---- hw/alu_if.sv ----
// Operand and result bundle between the datapath top and its ALU
`timescale 1ns/10ps
interface alu_if;
  alu_pkg::op_type op;
  logic [7:0]      acc;
  logic [7:0]      opnd;
  logic [7:0]      lit;
  logic            c_in;
  logic [7:0]      result;
  logic            c_out;
  logic            dig_out;
  logic            z_out;
  logic            wr_c;
  logic            wr_dig;
  logic            wr_z;

  modport core (
    input  op, acc, opnd, lit, c_in,
    output result, c_out, dig_out, z_out, wr_c, wr_dig, wr_z
  );
  modport user (
    output op, acc, opnd, lit, c_in,
    input  result, c_out, dig_out, z_out, wr_c, wr_dig, wr_z
  );
endinterface

// ---- hw/alu_exec.sv ----
// Combinational result and flag logic for the six operations
`timescale 1ns/10ps
module alu_exec (
  // Operands in, results out
  alu_if.core bus
);

  logic [8:0] diff;
  logic [4:0] ndiff;

  // Borrow seen in bit 8 and bit 4 of zero-extended differences
  assign diff  = {1'b0, bus.opnd} - {1'b0, bus.acc};
  assign ndiff = {1'b0, bus.opnd[3:0]} - {1'b0, bus.acc[3:0]};

  // Result and flag-write selection per operation
  always_comb begin
    bus.result = 8'h00;
    bus.c_out  = 1'b0;
    bus.dig_out = 1'b0;
    bus.wr_c   = 1'b0;
    bus.wr_dig = 1'b0;
    bus.wr_z   = 1'b0;
    unique case (bus.op)
      alu_pkg::OP_SUB: begin
        bus.result = diff[7:0];
        bus.c_out  = ~diff[8];
        bus.dig_out = ~ndiff[4];
        bus.wr_c   = 1'b1;
        bus.wr_dig = 1'b1;
        bus.wr_z   = 1'b1;
      end
      alu_pkg::OP_ROR: begin
        bus.result = {bus.c_in, bus.opnd[7:1]};
        bus.c_out  = bus.opnd[0];
        bus.wr_c   = 1'b1;
      end
      alu_pkg::OP_SWAP: begin
        bus.result = {bus.opnd[3:0], bus.opnd[7:4]};
      end
      alu_pkg::OP_DIR: begin
        bus.result = bus.acc;
      end
      alu_pkg::OP_XORL: begin
        bus.result = bus.acc ^ bus.lit;
        bus.wr_z   = 1'b1;
      end
      alu_pkg::OP_XORR: begin
        bus.result = bus.acc ^ bus.opnd;
        bus.wr_z   = 1'b1;
      end
      default: begin
        bus.result = 8'h00;
      end
    endcase
  end

  // Zero test on the full eight-bit result
  assign bus.z_out = (bus.result == 8'h00);

endmodule

// ---- test/tb.sv ----
// Self-checking bench for the subtract/rotate/swap/xor datapath
`timescale 1ns/10ps
module tb;
  logic        pclk;
  logic        presetn;
  logic        pce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  port_dir0;
  logic [7:0]  port_dir1;
  logic [31:0] rd;
  logic        er;
  int          fail_count;
  int          check_count;

  // Clock enable driven by the bench; one scenario holds it low
  alu_subtract_rotate_swap_xor dut_u (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_dir0(port_dir0), .port_dir1(port_dir1)
  );

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Read at the edge itself: flop outputs still show pre-edge values
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      fail_count++;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, er}, 32'h0);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  function automatic logic [11:0] fa(input logic [4:0] f);
    return alu_pkg::ADDR_FILE + {5'h00, f, 2'h0};
  endfunction

  // Instruction word: literal, file select, destination, op code
  task automatic ex(input logic [2:0] op, input logic d,
                    input logic [4:0] f, input logic [7:0] lit);
    wr(alu_pkg::ADDR_INSN, {8'h00, lit, 7'h00, f, d, op});
  endtask

  task automatic t_reset;
    rc(alu_pkg::ADDR_ACC, 32'h0);
    rc(alu_pkg::ADDR_FLAGS, 32'h0);
    rc(alu_pkg::ADDR_DIR0, 32'hFF);
    // Ports settle only after the access edge, so look mid-cycle
    @(negedge pclk);
    chk({16'h0, port_dir1, port_dir0}, 32'hFFFF);
    chk({31'h0, pready}, 32'h0);
    $display("test reset done");
  endtask

  // Borrow, equal, nibble borrow and plain cases; f at both ends
  task automatic t_sub;
    logic [7:0] av [4] = '{8'h35, 8'h12, 8'h20, 8'h18};
    logic [7:0] wv [4] = '{8'h12, 8'h35, 8'h20, 8'h09};
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      r = av[i] - wv[i];
      wr(fa(5'h1F), {24'h0, av[i]});
      wr(alu_pkg::ADDR_ACC, {24'h0, wv[i]});
      ex(alu_pkg::OP_SUB, 1'b0, 5'h1F, 8'h00);
      rc(alu_pkg::ADDR_ACC, {24'h0, r});
      rc(alu_pkg::ADDR_FLAGS, {29'h0, r == 8'h00,
         av[i][3:0] >= wv[i][3:0], av[i] >= wv[i]});
    end
    wr(fa(5'h00), 32'h05);
    wr(alu_pkg::ADDR_ACC, 32'h07);
    ex(alu_pkg::OP_SUB, 1'b1, 5'h00, 8'h00);
    rc(fa(5'h00), 32'hFE);
    rc(alu_pkg::ADDR_ACC, 32'h07);
    $display("test sub done");
  endtask

  task automatic t_rotate;
    wr(alu_pkg::ADDR_FLAGS, 32'h7);
    wr(fa(5'h03), 32'h81);
    ex(alu_pkg::OP_ROR, 1'b0, 5'h03, 8'h00);
    rc(alu_pkg::ADDR_ACC, 32'hC0);
    rc(alu_pkg::ADDR_FLAGS, 32'h7);
    wr(alu_pkg::ADDR_FLAGS, 32'h0);
    ex(alu_pkg::OP_ROR, 1'b1, 5'h03, 8'h00);
    rc(fa(5'h03), 32'h40);
    rc(alu_pkg::ADDR_FLAGS, 32'h1);
    $display("test rotate done");
  endtask

  task automatic t_swap;
    wr(alu_pkg::ADDR_FLAGS, 32'h5);
    wr(fa(5'h0A), 32'hA5);
    ex(alu_pkg::OP_SWAP, 1'b1, 5'h0A, 8'h00);
    rc(fa(5'h0A), 32'h5A);
    wr(fa(5'h0B), 32'h00);
    ex(alu_pkg::OP_SWAP, 1'b0, 5'h0B, 8'h00);
    rc(alu_pkg::ADDR_ACC, 32'h00);
    rc(alu_pkg::ADDR_FLAGS, 32'h5);
    $display("test swap done");
  endtask

  task automatic t_dir;
    wr(alu_pkg::ADDR_FLAGS, 32'h2);
    wr(alu_pkg::ADDR_ACC, 32'h3C);
    ex(alu_pkg::OP_DIR, 1'b0, 5'h06, 8'h00);
    @(negedge pclk);
    chk({24'h0, port_dir0}, 32'h3C);
    chk({24'h0, port_dir1}, 32'hFF);
    wr(alu_pkg::ADDR_ACC, 32'hC3);
    ex(alu_pkg::OP_DIR, 1'b0, 5'h07, 8'h00);
    rc(alu_pkg::ADDR_DIR1, 32'hC3);
    apb(1'b1, alu_pkg::ADDR_INSN, 32'h0000_0053);
    chk({31'h0, er}, 32'h1);
    @(negedge pclk);
    chk({16'h0, port_dir1, port_dir0}, 32'hC33C);
    rc(alu_pkg::ADDR_FLAGS, 32'h2);
    $display("test direction done");
  endtask

  task automatic t_xor;
    wr(alu_pkg::ADDR_FLAGS, 32'h3);
    wr(alu_pkg::ADDR_ACC, 32'h5A);
    ex(alu_pkg::OP_XORL, 1'b1, 5'h00, 8'h5A);
    rc(alu_pkg::ADDR_ACC, 32'h00);
    rc(alu_pkg::ADDR_FLAGS, 32'h7);
    ex(alu_pkg::OP_XORL, 1'b0, 5'h00, 8'hFF);
    rc(alu_pkg::ADDR_ACC, 32'hFF);
    rc(alu_pkg::ADDR_FLAGS, 32'h3);
    wr(alu_pkg::ADDR_ACC, 32'hF0);
    wr(fa(5'h09), 32'h0F);
    ex(alu_pkg::OP_XORR, 1'b1, 5'h09, 8'h00);
    rc(fa(5'h09), 32'hFF);
    rc(alu_pkg::ADDR_ACC, 32'hF0);
    ex(alu_pkg::OP_XORR, 1'b0, 5'h09, 8'h00);
    rc(alu_pkg::ADDR_ACC, 32'h0F);
    rc(alu_pkg::ADDR_FLAGS, 32'h3);
    $display("test xor done");
  endtask

  // Unmapped read and refused op code leave state alone
  task automatic t_err;
    apb(1'b0, 12'h040, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, alu_pkg::ADDR_INSN, 32'h0000_0006);
    chk({31'h0, er}, 32'h1);
    rc(alu_pkg::ADDR_ACC, 32'h0F);
    // Last accepted word: the register xor, not the refused ones
    rc(alu_pkg::ADDR_INSN, 32'h0000_0095);
    wr(alu_pkg::ADDR_DIR1, 32'h0000_0081);
    rc(alu_pkg::ADDR_DIR1, 32'h81);
    $display("test errors done");
  endtask

  // Enable low stretches setup: no ready and no write until it rises
  task automatic t_freeze;
    @(posedge pclk);
    pce     <= 1'b0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= 1'b1;
    paddr   <= alu_pkg::ADDR_ACC;
    pwdata  <= 32'h0000_0033;
    repeat (3) @(posedge pclk);
    chk({31'h0, pready}, 32'h0);
    pce     <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    chk({31'h0, pready}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
    rc(alu_pkg::ADDR_ACC, 32'h33);
    $display("test freeze done");
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog: the tests need a few hundred cycles
  initial begin
    #100000;
    fail_count++;
    final_report;
  end

  // Main sequence
  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    pce     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_sub;
    t_rotate;
    t_swap;
    t_dir;
    t_xor;
    t_err;
    t_freeze;
    final_report;
  end
endmodule
